/* File: design/sppc_pkg.sv */
package sppc_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 20_000_000;
    localparam int SPU_UNIT_US = 16; // Shortest predefined pulse, microseconds
    localparam int SPU_UNIT_CYC = (SPU_UNIT_US * CLK_HZ + 999_999) / 1_000_000;
    localparam int CNT_W = 24;

    // ------------------------------------------------------------
    // Duration value codes
    // ------------------------------------------------------------
    localparam logic [2:0] CODE_INF = 3'h7;
    localparam logic [2:0] CODE_DYN = 3'h6; // Strong pullup only

    // ------------------------------------------------------------
    // Command bytes and fields
    // ------------------------------------------------------------
    localparam logic [7:0] PULSE_MASK = 8'hed;
    localparam logic [7:0] PULSE_VAL = 8'hed;
    localparam logic [7:0] BYTE_TERM = 8'hf1;
    localparam int ARM_BIT = 1;
    localparam int PROG_BIT = 4;
    localparam logic [7:0] RESP_MASK = 8'hfc;
    localparam logic [7:0] RESP_SPU = 8'hec;

    // ------------------------------------------------------------
    // Control states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00, // No pulse
        ST_TERM = 2'b01, // Pulse from command mode, may be terminated
        ST_LOCK = 2'b10  // Armed data-mode pullup, not terminable
    } sppc_state_t;

endpackage : sppc_pkg

/* File: design/sppc_pulse_if.sv */
`timescale 1ns/1ns
// Controller to pulse timer
interface sppc_pulse_if;
    logic start;
    logic prog;
    logic term;
    logic [2:0] code;
    logic spu_on;
    logic pp_on;
    logic inf;
    logic done;
    modport ctrl (output start, prog, term, code, input spu_on, pp_on, inf, done);
    modport timer (input start, prog, term, code, output spu_on, pp_on, inf, done);
endinterface : sppc_pulse_if

/* File: design/sppc_timer.sv */
`timescale 1ns/1ns
module sppc_timer #(
    parameter int UNIT_CYC = sppc_pkg::SPU_UNIT_CYC
) (
    input wire logic clk_in,       // System clock
    input wire logic rst_n_in,     // Async reset, active low
    input wire logic load_low_in,  // Load sensor: demand below threshold
    sppc_pulse_if.timer pif        // Controller side
);

    logic ld_meta_reg;
    logic ld_sync_reg;
    logic [sppc_pkg::CNT_W-1:0] cnt_reg;
    logic inf_reg;
    logic dyn_reg;
    logic spu_reg;
    logic pp_reg;
    logic done_reg;
    logic active;
    logic end_now;
    logic [sppc_pkg::CNT_W-1:0] run_reg;
    logic [2:0] code_reg;

    // Predefined length grows by powers of two with the code
    function automatic logic [sppc_pkg::CNT_W-1:0] dur_cyc(input logic [2:0] code);
        dur_cyc = sppc_pkg::CNT_W'(UNIT_CYC) << code;
    endfunction : dur_cyc

    // ------------------------------------------------------------
    // Load sensor synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ld_meta_reg <= 1'b0;
            ld_sync_reg <= 1'b0;
        end else begin
            ld_meta_reg <= load_low_in;
            ld_sync_reg <= ld_meta_reg;
        end
    end

    // ------------------------------------------------------------
    // Pulse timing
    // ------------------------------------------------------------
    assign active = spu_reg | pp_reg;
    // Infinite waits for terminate; dynamic for the sensor; else count
    assign end_now = active && ((inf_reg && pif.term)
                             || (dyn_reg && ld_sync_reg)
                             || (!inf_reg && !dyn_reg && cnt_reg == 1));

    // Start wins over end so a back-to-back request is never lost
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            spu_reg <= 1'b0;
            pp_reg <= 1'b0;
            inf_reg <= 1'b0;
            dyn_reg <= 1'b0;
            cnt_reg <= '0;
        end else if (pif.start) begin
            spu_reg <= !pif.prog;
            pp_reg <= pif.prog;
            inf_reg <= pif.code == sppc_pkg::CODE_INF;
            dyn_reg <= !pif.prog && pif.code == sppc_pkg::CODE_DYN;
            cnt_reg <= dur_cyc(pif.code);
        end else if (end_now) begin
            spu_reg <= 1'b0;
            pp_reg <= 1'b0;
        end else if (active && cnt_reg != 0) begin
            cnt_reg <= cnt_reg - 1'b1;
        end
    end

    // End of pulse notice, one cycle
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            done_reg <= 1'b0;
        end else begin
            done_reg <= end_now && !pif.start;
        end
    end

    assign pif.spu_on = spu_reg;
    assign pif.pp_on = pp_reg;
    assign pif.inf = inf_reg;
    assign pif.done = done_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Check helper: cycles the pulse has stood, and the code it began with
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            run_reg <= '0;
            code_reg <= 3'h0;
        end else if (pif.start) begin
            run_reg <= '0;
            code_reg <= pif.code;
        end else if (active) begin
            run_reg <= run_reg + 1'b1;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    chk_dyn_end: assert property (active && dyn_reg && ld_sync_reg && !pif.start |=> !active)
        else $error("dynamic pulse outlived load drop");
    chk_inf_hold: assert property (active && inf_reg && !pif.term |=> active)
        else $error("infinite pulse ended without terminate");
    // Length is counted, not repeated, so any unit size is checked exactly
    chk_fixed_len: assert property ($fell(active) && !inf_reg && !dyn_reg
        |-> run_reg == dur_cyc(code_reg))
        else $error("predefined pulse length wrong");

endmodule : sppc_timer

/* File: design/sppc_ctrl.sv */
`timescale 1ns/1ns
//
// Overview of operation
// - Programming pulse length is predefined for duration codes 000 to 110.
// - Strong pullup length is predefined for duration codes 000 to 101.
// - Dynamic duration ends the pulse when the load sensor reports low demand.
// - Code 111 holds the pulse until the host terminates it.
// - Bit 1 of a pulse command arms the strong pullup; zero disarms.
// - Pulse starts as the command byte arrives; its response follows the end.
// - Terminate byte ends an infinite pulse at once, then pulse response goes.
// - Terminate byte in command mode gets no response of its own; in data mode it goes to the bus as data.
// - Armed in data mode, every transferred byte is followed by a pullup.
// - After 8th slot: pullup and data response together, pulse response at end.
// - Data-mode pullup cannot be terminated; infinite there hangs until reset.
// - Single bit command picks its pullup from its own bit 1.
// - Single bit pullup honours all durations, dynamic and infinite too.
// - Single bit: pullup and bit response together, pulse response at end.
// - Single bit infinite pullup holds until terminate, then pulse response.
// - One received byte is buffered while the previous one executes.
//
module sppc_ctrl #(
    parameter int UNIT_CYC = sppc_pkg::SPU_UNIT_CYC
) (
    input wire logic clk_in,             // 20 MHz clock
    input wire logic rst_n_in,           // Async reset, active low
    input wire logic [7:0] rx_byte_in,   // Byte from host receiver
    input wire logic rx_valid_in,        // Host byte strobe
    input wire logic data_mode_in,       // Device is in data mode
    input wire logic [2:0] spu_code_in,  // Strong pullup duration code
    input wire logic [2:0] ppd_code_in,  // Programming pulse duration code
    input wire logic exec_ready_in,      // Bus engine takes a byte
    input wire logic done_in,            // Bus engine finished a byte or bit
    input wire logic [7:0] done_resp_in, // Response of finished work
    input wire logic done_bit_in,        // Finished work was a single bit
    input wire logic done_spu_in,        // Bit 1 of that single bit command
    input wire logic tx_ready_in,        // Host transmitter takes a byte
    input wire logic load_low_in,        // Load sensor pin, asynchronous
    input wire logic overrun_clr_in,     // Clear overrun flag
    output logic [7:0] exec_byte_out,    // Byte for bus engine
    output logic exec_valid_out,         // Byte offered to bus engine
    output logic [7:0] tx_byte_out,      // Response byte to host
    output logic tx_valid_out,           // Response offered to host
    output logic spu_out,                // Strong 5V pullup on
    output logic ppe_out,                // 12V programming pulse on
    output logic armed_out,              // Strong pullup armed
    output logic overrun_out             // Host byte lost
);

    sppc_pulse_if pif ();

    sppc_pkg::sppc_state_t st_reg;
    sppc_pkg::sppc_state_t st_next;
    logic [7:0] buf_reg;
    logic buf_full_reg;
    logic armed_reg;
    logic overrun_reg;
    logic [7:0] exec_byte_reg;
    logic exec_valid_reg;
    logic exec_busy_reg;
    logic [7:0] resp_reg;
    logic [7:0] tx_byte_reg;
    logic tx_valid_reg;
    logic [7:0] pend_byte_reg;
    logic pend_vld_reg;
    logic is_pulse;
    logic is_term;
    logic can_go;
    logic start_cmd;
    logic fwd;
    logic drop_term;
    logic term_hit;
    logic consume;
    logic post_bit;
    logic post_arm;
    logic enq;
    logic [7:0] enq_byte;
    logic tx_free;

    function automatic logic pulse_cmd(input logic [7:0] b);
        pulse_cmd = (b & sppc_pkg::PULSE_MASK) == sppc_pkg::PULSE_VAL;
    endfunction : pulse_cmd

    sppc_timer #(
        .UNIT_CYC(UNIT_CYC)
    ) u_timer (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .load_low_in(load_low_in),
        .pif(pif.timer)
    );

    // ------------------------------------------------------------
    // Buffer decode
    // ------------------------------------------------------------
    assign is_pulse = pulse_cmd(buf_reg);
    assign is_term = buf_reg == sppc_pkg::BYTE_TERM;
    // Issue only with both response slots free: bounds queue to two bytes
    assign can_go = buf_full_reg && st_reg == sppc_pkg::ST_IDLE && !exec_busy_reg
        && !exec_valid_reg && !done_in && !tx_valid_reg && !pend_vld_reg;
    assign start_cmd = can_go && is_pulse && !data_mode_in;
    assign drop_term = can_go && is_term && !data_mode_in;
    // In data mode every byte, terminate included, goes to the bus
    assign fwd = can_go && !start_cmd && !drop_term;
    // Only terminate leaves the buffer while an infinite pulse runs
    assign term_hit = buf_full_reg && st_reg == sppc_pkg::ST_TERM && pif.inf && is_term;
    assign consume = start_cmd || fwd || drop_term || term_hit;

    // ------------------------------------------------------------
    // Pullups after bus work
    // ------------------------------------------------------------
    assign post_bit = done_in && done_bit_in && done_spu_in;
    assign post_arm = done_in && !done_bit_in && data_mode_in && armed_reg;

    assign pif.start = start_cmd || post_bit || post_arm;
    assign pif.prog = start_cmd && buf_reg[sppc_pkg::PROG_BIT];
    assign pif.code = pif.prog ? ppd_code_in : spu_code_in;
    assign pif.term = term_hit;

    // ------------------------------------------------------------
    // One-byte receive buffer
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            buf_reg <= 8'h00;
            buf_full_reg <= 1'b0;
        end else if (rx_valid_in && (!buf_full_reg || consume)) begin
            buf_reg <= rx_byte_in;
            buf_full_reg <= 1'b1;
        end else if (consume) begin
            buf_full_reg <= 1'b0;
        end
    end

    // Overrun flag; a new loss beats a clear in the same cycle
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            overrun_reg <= 1'b0;
        end else if (rx_valid_in && buf_full_reg && !consume) begin
            overrun_reg <= 1'b1;
        end else if (overrun_clr_in) begin
            overrun_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Bus engine hand-off
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            exec_byte_reg <= 8'h00;
            exec_valid_reg <= 1'b0;
        end else if (fwd) begin
            exec_byte_reg <= buf_reg;
            exec_valid_reg <= 1'b1;
        end else if (exec_ready_in) begin
            exec_valid_reg <= 1'b0;
        end
    end

    // Busy from hand-off to finish; keeps pulses off a running slot
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            exec_busy_reg <= 1'b0;
        end else if (fwd) begin
            exec_busy_reg <= 1'b1;
        end else if (done_in) begin
            exec_busy_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Arming and pulse response
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            armed_reg <= 1'b0;
        end else if (start_cmd) begin
            armed_reg <= buf_reg[sppc_pkg::ARM_BIT];
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            resp_reg <= 8'h00;
        end else if (start_cmd) begin
            resp_reg <= buf_reg & sppc_pkg::RESP_MASK;
        end else if (post_bit || post_arm) begin
            resp_reg <= sppc_pkg::RESP_SPU;
        end
    end

    // ------------------------------------------------------------
    // Control state
    // ------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        case (st_reg)
            sppc_pkg::ST_IDLE: begin
                if (start_cmd || post_bit) begin
                    st_next = sppc_pkg::ST_TERM;
                end else if (post_arm) begin
                    st_next = sppc_pkg::ST_LOCK;
                end
            end
            sppc_pkg::ST_TERM, sppc_pkg::ST_LOCK: begin
                if (pif.done) begin
                    st_next = sppc_pkg::ST_IDLE;
                end
            end
            default: begin
                st_next = sppc_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_reg <= sppc_pkg::ST_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // Response queue: output slot plus one pending
    // ------------------------------------------------------------
    // Terminate never enqueues; only bus work and pulse ends do
    assign enq = done_in || pif.done;
    assign enq_byte = pif.done ? resp_reg : done_resp_in;
    assign tx_free = !tx_valid_reg || tx_ready_in;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tx_byte_reg <= 8'h00;
            tx_valid_reg <= 1'b0;
            pend_byte_reg <= 8'h00;
            pend_vld_reg <= 1'b0;
        end else if (tx_free) begin
            if (pend_vld_reg) begin
                tx_byte_reg <= pend_byte_reg;
                tx_valid_reg <= 1'b1;
                pend_vld_reg <= enq;
                pend_byte_reg <= enq_byte;
            end else begin
                tx_byte_reg <= enq_byte;
                tx_valid_reg <= enq;
            end
        end else if (enq) begin
            pend_byte_reg <= enq_byte;
            pend_vld_reg <= 1'b1;
        end
    end

    assign exec_byte_out = exec_byte_reg;
    assign exec_valid_out = exec_valid_reg;
    assign tx_byte_out = tx_byte_reg;
    assign tx_valid_out = tx_valid_reg;
    assign spu_out = pif.spu_on;
    assign ppe_out = pif.pp_on;
    assign armed_out = armed_reg;
    assign overrun_out = overrun_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    chk_pulse_start: assert property (start_cmd |=> spu_out || ppe_out)
        else $error("pulse did not start on command");
    chk_arm_bit: assert property (start_cmd |=> armed_out == $past(buf_reg[1]))
        else $error("arm state differs from command bit");
    chk_term_end: assert property (term_hit |=> ##1 !spu_out && !ppe_out)
        else $error("terminate did not end pulse");
    chk_term_silent: assert property (term_hit && !tx_valid_out |=> !tx_valid_out)
        else $error("terminate produced a response");
    chk_pulse_resp: assert property (pif.done && !tx_valid_out && !pend_vld_reg
        |=> tx_valid_out && tx_byte_out == $past(resp_reg))
        else $error("no pulse response at pulse end");
    chk_data_pullup: assert property (post_arm && !tx_valid_out
        |=> spu_out && tx_valid_out)
        else $error("armed pullup and data response not together");
    chk_bit_pullup: assert property (post_bit |=> spu_out && st_reg == sppc_pkg::ST_TERM)
        else $error("single bit pullup missing");
    chk_hold_buffer: assert property (buf_full_reg && st_reg != sppc_pkg::ST_IDLE && !term_hit
        |=> buf_full_reg)
        else $error("byte left buffer during pulse");

endmodule : sppc_ctrl

/* File: sim/sppc_far_model.sv */
`timescale 1ns/1ns
// ------------------------------------------------------------
// Bus engine and host transmitter stand-in
// ------------------------------------------------------------
module sppc_far_model (
    input wire logic clk_in,             // System clock
    input wire logic rst_n_in,           // Async reset, active low
    input wire logic [7:0] exec_byte_in, // Byte to execute
    input wire logic exec_valid_in,      // Byte offered
    input wire logic bit_mode_in,        // Treat work as single bit commands
    output logic exec_ready_out,         // Takes a byte
    output logic done_out,               // Work finished
    output logic [7:0] done_resp_out,    // Response of work
    output logic done_bit_out,           // Work was a single bit
    output logic done_spu_out,           // Bit 1 of single bit code
    output logic tx_ready_out            // Host takes a response
);
    logic [7:0] job_reg;
    logic [3:0] wait_reg;
    logic busy_reg;
    logic fin;

    assign fin = busy_reg && (wait_reg == 4'h1);

    // Six cycles a job; ready stalls every other cycle, off-cycle outputs show garbage
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            job_reg <= 8'h00;
            wait_reg <= 4'h0;
            busy_reg <= 1'b0;
            exec_ready_out <= 1'b0;
            done_out <= 1'b0;
            done_resp_out <= 8'h00;
            done_bit_out <= 1'b0;
            done_spu_out <= 1'b0;
            tx_ready_out <= 1'b0;
        end else begin
            tx_ready_out <= ~tx_ready_out;
            done_out <= fin;
            done_resp_out <= fin ? job_reg : ~job_reg;
            done_bit_out <= fin ? bit_mode_in : ~bit_mode_in;
            done_spu_out <= fin ? (job_reg[1] & bit_mode_in) : ~job_reg[1];
            if (exec_valid_in && exec_ready_out && !busy_reg) begin
                job_reg <= exec_byte_in;
                wait_reg <= 4'h6;
                busy_reg <= 1'b1;
                exec_ready_out <= 1'b0;
            end else if (busy_reg) begin
                wait_reg <= wait_reg - 4'h1;
                busy_reg <= !fin;
            end else begin
                exec_ready_out <= ~exec_ready_out;
            end
        end
    end
endmodule : sppc_far_model

/* File: sim/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
    localparam int UNIT = 2; // Short unit keeps fixed pulses brief
    typedef struct {
        logic [7:0] cmd;
        logic [2:0] spu;
        logic [2:0] ppd;
        int spu_len;
        int pp_len;
        logic [7:0] resp;
        logic arm;
    } sppc_row_t;

    logic clk_in, rst_n_in, rx_valid, data_mode, exec_ready, done, done_bit, done_spu;
    logic tx_ready, load_low, overrun_clr, exec_valid, tx_valid, spu, ppe, armed, overrun;
    logic bit_mode;
    logic [7:0] rx_byte, done_resp, exec_byte, tx_byte;
    logic [2:0] spu_code, ppd_code;
    logic [7:0] txq[$];
    sppc_row_t rows[14];
    int fails = 0;
    int compares = 0;
    int cycles = 0;
    int cnt_spu, cnt_pp;

    sppc_ctrl #(.UNIT_CYC(UNIT)) DUT (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .rx_byte_in(rx_byte), .rx_valid_in(rx_valid), .data_mode_in(data_mode),
        .spu_code_in(spu_code), .ppd_code_in(ppd_code), .exec_ready_in(exec_ready),
        .done_in(done), .done_resp_in(done_resp), .done_bit_in(done_bit),
        .done_spu_in(done_spu), .tx_ready_in(tx_ready), .load_low_in(load_low),
        .overrun_clr_in(overrun_clr), .exec_byte_out(exec_byte),
        .exec_valid_out(exec_valid), .tx_byte_out(tx_byte), .tx_valid_out(tx_valid),
        .spu_out(spu), .ppe_out(ppe), .armed_out(armed), .overrun_out(overrun));

    sppc_far_model far (.clk_in(clk_in), .rst_n_in(rst_n_in), .exec_byte_in(exec_byte),
        .exec_valid_in(exec_valid), .bit_mode_in(bit_mode), .exec_ready_out(exec_ready),
        .done_out(done), .done_resp_out(done_resp), .done_bit_out(done_bit),
        .done_spu_out(done_spu), .tx_ready_out(tx_ready));

    // ------------------------------------------------------------
    // Clock, response capture and hang guard
    // ------------------------------------------------------------
    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end

    always @(posedge clk_in) begin
        if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
            txq.push_back(tx_byte);
        end
        cycles++;
        if (cycles == 20000) begin
            fails++;
            wrap_up();
        end
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One cycle; pulse cycles are tallied at the falling edge
    task automatic tick();
        @(negedge clk_in);
        if (spu === 1'b1) cnt_spu++;
        if (ppe === 1'b1) cnt_pp++;
    endtask : tick

    task automatic run(input int n);
        repeat (n) tick();
    endtask : run

    task automatic send(input logic [7:0] b);
        @(negedge clk_in);
        rx_byte = b;
        rx_valid = 1'b1;
        tick();
        rx_valid = 1'b0;
    endtask : send

    task automatic expect_tx(input logic [7:0] exp);
        int n;
        n = 0;
        while (txq.size() == 0 && n < 3000) begin
            tick();
            n++;
        end
        chk((txq.size() != 0) ? txq.pop_front() : ~exp, exp);
    endtask : expect_tx

    task automatic wrap_up();
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : wrap_up

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {rst_n_in, rx_valid, data_mode, load_low, overrun_clr, bit_mode} = 6'h00;
        {rx_byte, spu_code, ppd_code} = 14'h0000;
        for (int i = 0; i < 6; i++) rows[i] = '{8'hed, 3'(i), 3'h0, UNIT << i, 0, 8'hec, 1'b0};
        for (int i = 0; i < 7; i++) rows[6+i] = '{8'hfd, 3'h0, 3'(i), 0, UNIT << i, 8'hfc, 1'b0};
        rows[13] = '{8'hef, 3'h0, 3'h0, UNIT, 0, 8'hec, 1'b1}; // Leaves the pullup armed
        repeat (2) @(negedge clk_in);
        rst_n_in = 1'b1;
        // Fixed lengths of both pulse kinds, arm bit
        foreach (rows[i]) begin
            spu_code = rows[i].spu;
            ppd_code = rows[i].ppd;
            cnt_spu = 0;
            cnt_pp = 0;
            send(rows[i].cmd);
            expect_tx(rows[i].resp);
            chk(8'(cnt_spu), 8'(rows[i].spu_len));
            chk(8'(cnt_pp), 8'(rows[i].pp_len));
            chk(armed, rows[i].arm);
        end
        // Armed data mode: data answer, pullup, then pulse answer; terminate is data
        data_mode = 1'b1;
        cnt_spu = 0;
        send(8'h44);
        expect_tx(8'h44);
        expect_tx(8'hec);
        chk(8'(cnt_spu), 8'(UNIT));
        send(8'hf1);
        expect_tx(8'hf1);
        expect_tx(8'hec);
        data_mode = 1'b0;
        send(8'hed);
        expect_tx(8'hec);
        chk(armed, 1'b0);
        // Dynamic pullup ends shortly after the sensor reports low demand
        spu_code = 3'h6;
        send(8'hed);
        run(12);
        chk(spu, 1'b1);
        load_low = 1'b1;
        cnt_spu = 0;
        expect_tx(8'hec);
        chk(8'(cnt_spu <= 5), 8'h01);
        load_low = 1'b0;
        // Infinite programming pulse ended by terminate, which gets no answer
        ppd_code = 3'h7;
        send(8'hfd);
        run(40);
        chk(ppe, 1'b1);
        chk(8'(txq.size()), 8'h00);
        cnt_pp = 0;
        send(8'hf1);
        expect_tx(8'hfc);
        chk(8'(cnt_pp <= 3), 8'h01);
        run(30);
        chk(8'(txq.size()), 8'h00);
        chk(ppe, 1'b0);
        // Terminate with no pulse running is dropped, not sent to the bus
        send(8'hf1);
        run(20);
        chk(8'(txq.size()), 8'h00);
        // Single bit commands: own pullup bit, fixed, off, infinite, dynamic
        bit_mode = 1'b1;
        spu_code = 3'h2;
        cnt_spu = 0;
        send(8'h83);
        expect_tx(8'h83);
        expect_tx(8'hec);
        chk(8'(cnt_spu), 8'(UNIT << 2));
        cnt_spu = 0;
        send(8'h81);
        expect_tx(8'h81);
        run(20);
        chk(8'(cnt_spu), 8'h00);
        chk(8'(txq.size()), 8'h00);
        spu_code = 3'h7;
        send(8'h83);
        expect_tx(8'h83);
        run(30);
        chk(spu, 1'b1);
        send(8'hf1);
        expect_tx(8'hec);
        run(5);
        chk(spu, 1'b0);
        spu_code = 3'h6;
        send(8'h83);
        expect_tx(8'h83);
        run(10);
        chk(spu, 1'b1);
        load_low = 1'b1;
        expect_tx(8'hec);
        load_low = 1'b0;
        bit_mode = 1'b0;
        // Other bytes wait during an infinite pulse; a third one overruns
        ppd_code = 3'h7;
        send(8'hfd);
        run(10);
        send(8'h33);
        run(10);
        chk(ppe, 1'b1);
        chk(exec_valid, 1'b0);
        send(8'h55);
        run(1);
        chk(overrun, 1'b1);
        overrun_clr = 1'b1;
        run(1);
        overrun_clr = 1'b0;
        run(1);
        chk(overrun, 1'b0);
        // Reset in mid-pulse is the only way out of a stuck pulse
        rst_n_in = 1'b0;
        run(2);
        chk({2'b00, spu, ppe, armed, overrun, tx_valid, exec_valid}, 8'h00);
        rst_n_in = 1'b1;
        run(2);
        chk({2'b00, spu, ppe, armed, overrun, tx_valid, exec_valid}, 8'h00);
        wrap_up();
    end
endmodule : tb_top
